/* core/dtc_timer_counter.sv */
// How it works
// R1 - Overflow flags set, cleared on vectoring
// R2 - Run bits switch timers zero/one
// R3 - External requests set by edge or level
// R4 - Vector clear only for edge requests
// R5 - Trigger type selects edge or level
// R6 - Mode 0 is thirteen-bit counter
// R7 - Rollover to zero sets overflow flag
// R8 - Counting needs run and gate-or-pin high
// R9 - Setting run keeps count registers
// R10 - Mode 1 is full sixteen-bit counter
// R11 - Mode 2 reloads low from high
// R12 - Timer one mode 3 holds count
// R13 - Timer zero mode 3 splits bytes
// R14 - Timer one still feeds baud ticks
// R15 - Timer two overflow flag, not in baud
// R16 - External flag on trigger falling edge
// R17 - Clock-source bits route baud overflows
// R18 - External enable gates trigger pin
// R19 - Timer two run bit starts/stops
// R20 - Function select picks pin or clock
// R21 - Capture or reload select
// R22 - Baud use forces auto-reload
// R23 - Timer function counts machine cycles; timer two counts every core clock instead
// R24 - Count pin sampled per machine cycle
// R25 - Count pin levels held one machine cycle
`timescale 1ns/10ps
`include "dtc_regs.svh"

module dtc_timer_counter #(
  parameter int McClocks = `DTC_MC_CLOCKS // Core clocks per machine cycle
) (
  input wire logic clk, // Core clock, 50 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire dtc_pkg::dtc_byte_t regAddr, // Register address
  input wire dtc_pkg::dtc_byte_t regWdata, // Register write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output dtc_pkg::dtc_byte_t regRdata, // Read data, cycle after strobe
  input wire logic timerZeroCountPin, // Timer zero count input
  input wire logic timerOneCountPin, // Timer one count input
  input wire logic extIrqZeroPinN, // External interrupt zero, active low
  input wire logic extIrqOnePinN, // External interrupt one, active low
  input wire logic timerTwoCountPin, // Timer two count input
  input wire logic timerTwoTriggerPin, // Timer two trigger input
  input wire logic ackTimerZero, // Core vectors to timer zero routine
  input wire logic ackTimerOne, // Core vectors to timer one routine
  input wire logic ackExtZero, // Core vectors to ext zero routine
  input wire logic ackExtOne, // Core vectors to ext one routine
  output logic timerZeroIrq, // Timer zero overflow flag
  output logic timerOneIrq, // Timer one overflow flag
  output logic extZeroIrq, // External zero request flag
  output logic extOneIrq, // External one request flag
  output logic timerTwoIrq, // Timer two overflow or external flag
  output logic rxBaudTick, // Receive baud overflow pulse
  output logic txBaudTick // Transmit baud overflow pulse
);
  import dtc_pkg::*;

  localparam int PinCount = 6;
  localparam int PinT0 = 0, PinT1 = 1, PinX0 = 2;
  localparam int PinX1 = 3, PinT2 = 4, PinT2Ex = 5;
  localparam logic [3:0] McLast = 4'(McClocks - 1);
  // Next count of a timer pair for its mode: {overflow, high, low}
  function automatic logic [16:0] nextCount(dtc_mode_e mode, dtc_byte_t hi, dtc_byte_t lo);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    unique case (mode)
      DTC_MODE_13BIT: begin
        // Upper three low bits are left as they are [R6]
        res[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == `DTC_LOW5_ONES) begin
          res[15:8] = hi + 8'h01;
          res[16] = (hi == `DTC_BYTE_ONES); // [R7]
        end
      end
      DTC_MODE_16BIT: begin
        res[15:0] = {hi, lo} + 16'h0001; // [R10]
        res[16] = ({hi, lo} == `DTC_WORD_ONES); // [R7]
      end
      DTC_MODE_RELOAD8: begin
        if (lo == `DTC_BYTE_ONES) begin
          res[7:0] = hi; // Reload, high byte untouched [R11]
          res[16] = 1'b1;
        end else begin
          res[7:0] = lo + 8'h01;
        end
      end
      DTC_MODE_SPLIT: begin
        res[7:0] = lo + 8'h01; // Low byte alone [R13]
        res[16] = (lo == `DTC_BYTE_ONES);
      end
    endcase
    return res;
  endfunction

  logic [PinCount-1:0] pinRaw, sync1_q, sync2_q, prev_q;
  logic [2:0] mcSamp_q, mcPrev_q, cntEdge_q;
  logic [3:0] preCnt_q;
  dtc_byte_t ctrl_q, ctrl_d, mode_q, t2ctrl_q, t2ctrl_d, rdMux;
  dtc_byte_t tl0_q, th0_q, tl1_q, th1_q, tl0_d, th0_d, tl1_d, th1_d;
  logic [15:0] t2_q, t2_d, rcap_q, rcap_d;
  logic [16:0] t0Next, t1Next;
  dtc_mode_e t0Mode, t1Mode;
  logic mcTick, t0Split, tick0, tick1, tickTh0, tick2, t0Ovf, t1Ovf, th0Ovf;
  logic t2Ovf, t2Baud, t2Trig, x0Fall, x1Fall, wrCtrl, wrT2Ctrl;
  assign pinRaw = {timerTwoTriggerPin, timerTwoCountPin, extIrqOnePinN,
                   extIrqZeroPinN, timerOneCountPin, timerZeroCountPin};

  // Two-flop synchronisers; the second stage and its one-clock delayed copy feed logic
  genvar gi;
  generate
    for (gi = 0; gi < PinCount; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (reset) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          prev_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pinRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // Machine cycle prescaler, one tick per twelve core clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      preCnt_q <= 4'h0;
    end else if (preCnt_q == McLast) begin
      preCnt_q <= 4'h0;
    end else begin
      preCnt_q <= preCnt_q + 4'h1;
    end
  end
  assign mcTick = (preCnt_q == McLast); // [R23]

  // Count pins sampled once per machine cycle; a high then low sample
  // gives one count pulse, so pins faster than one level per machine
  // cycle lose counts [R24] [R25]
  always_ff @(posedge clk) begin
    if (reset) begin
      mcSamp_q <= 3'h7;
      mcPrev_q <= 3'h7;
      cntEdge_q <= 3'h0;
    end else begin
      if (mcTick) begin
        mcSamp_q <= {sync2_q[PinT2], sync2_q[PinT1], sync2_q[PinT0]};
        mcPrev_q <= mcSamp_q;
      end
      cntEdge_q <= preCnt_q == 4'h0 ? (mcPrev_q & ~mcSamp_q) : 3'h0; // [R24]
    end
  end

  // Falling edges on the interrupt and trigger pins
  assign x0Fall = prev_q[PinX0] & ~sync2_q[PinX0];
  assign x1Fall = prev_q[PinX1] & ~sync2_q[PinX1];
  assign t2Trig = prev_q[PinT2Ex] & ~sync2_q[PinT2Ex] &
                  t2ctrl_q[`DTC_BIT_T2_EXEN]; // Ignored while disabled [R18]
  assign wrCtrl = regWrite && (regAddr == `DTC_ADDR_CTRL);
  assign wrT2Ctrl = regWrite && (regAddr == `DTC_ADDR_T2_CTRL);
  // Count enables for timers zero and one
  assign t0Mode = dtc_mode_e'(mode_q[`DTC_BIT_T0_MODE_HI:`DTC_BIT_T0_MODE_LO]);
  assign t1Mode = dtc_mode_e'(mode_q[`DTC_BIT_T1_MODE_HI:`DTC_BIT_T1_MODE_LO]);
  assign t0Split = (t0Mode == DTC_MODE_SPLIT);
  assign tick0 = ctrl_q[`DTC_BIT_T0_RUN] && // [R2]
                 (!mode_q[`DTC_BIT_T0_GATE] || sync2_q[PinX0]) && // [R8]
                 (mode_q[`DTC_BIT_T0_CNT] ? cntEdge_q[0] : mcTick); // [R23] [R24]
  // Split mode hands timer one's run bit to the high byte of timer zero;
  // timer one then runs without its run bit, gate still applying, whenever it is out of its own mode 3
  assign tick1 = (t1Mode != DTC_MODE_SPLIT) && // [R12] [R14]
                 (t0Split || ctrl_q[`DTC_BIT_T1_RUN]) && // [R2] [R14]
                 (!mode_q[`DTC_BIT_T1_GATE] || sync2_q[PinX1]) && // [R8]
                 (mode_q[`DTC_BIT_T1_CNT] ? cntEdge_q[1] : mcTick);
  assign tickTh0 = t0Split && ctrl_q[`DTC_BIT_T1_RUN] && mcTick; // [R13]
  assign t0Next = nextCount(t0Mode, th0_q, tl0_q);
  // Timer one never ticks in its own mode 3, so that result is unused
  assign t1Next = nextCount(t1Mode, th1_q, tl1_q);
  assign t0Ovf = tick0 && t0Next[16];
  assign t1Ovf = tick1 && t1Next[16];
  assign th0Ovf = tickTh0 && (th0_q == `DTC_BYTE_ONES);
  // Next values of the counter bytes; a software write to a byte wins
  // over a count in the same cycle, and run bits never touch them [R9]
  always_comb begin
    tl0_d = tick0 ? t0Next[7:0] : tl0_q;
    th0_d = th0_q;
    if (t0Split) begin
      th0_d = tickTh0 ? th0_q + 8'h01 : th0_q; // [R13]
    end else if (tick0) begin
      th0_d = t0Next[15:8];
    end
    tl1_d = tick1 ? t1Next[7:0] : tl1_q;
    th1_d = tick1 ? t1Next[15:8] : th1_q; // Holds in mode 3 [R12]
    if (regWrite && regAddr == `DTC_ADDR_T0_LOW) begin
      tl0_d = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T0_HIGH) begin
      th0_d = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T1_LOW) begin
      tl1_d = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T1_HIGH) begin
      th1_d = regWdata;
    end
  end

  // Counter bytes of timers zero and one
  always_ff @(posedge clk) begin
    if (reset) begin
      tl0_q <= `DTC_RESET_BYTE;
      th0_q <= `DTC_RESET_BYTE;
      tl1_q <= `DTC_RESET_BYTE;
      th1_q <= `DTC_RESET_BYTE;
    end else begin
      tl0_q <= tl0_d;
      th0_q <= th0_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
    end
  end

  // Mode register, software only
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= `DTC_RESET_BYTE;
    end else if (regWrite && regAddr == `DTC_ADDR_MODE) begin
      mode_q <= regWdata;
    end
  end

  // Shared control register; a hardware set wins over a clear in the
  // same cycle, whether the clear is a write or a vectoring acknowledge
  always_comb begin
    ctrl_d = wrCtrl ? regWdata : ctrl_q; // Run and type bits [R2] [R5]
    if (!wrCtrl && ackTimerZero) begin
      ctrl_d[`DTC_BIT_T0_OVF] = 1'b0; // [R1]
    end
    if (!wrCtrl && ackTimerOne) begin
      ctrl_d[`DTC_BIT_T1_OVF] = 1'b0; // [R1]
    end
    if (t0Ovf) begin
      ctrl_d[`DTC_BIT_T0_OVF] = 1'b1; // [R1] [R7]
    end
    // Split mode: high byte of timer zero owns timer one's flag
    if (t0Split ? th0Ovf : t1Ovf) begin
      ctrl_d[`DTC_BIT_T1_OVF] = 1'b1; // [R1] [R13] [R14]
    end
    if (ctrl_q[`DTC_BIT_X0_TYPE]) begin
      if (!wrCtrl && ackExtZero) begin
        ctrl_d[`DTC_BIT_X0_REQ] = 1'b0; // [R4]
      end
      if (x0Fall) begin
        ctrl_d[`DTC_BIT_X0_REQ] = 1'b1; // [R3] [R5]
      end
    end else begin
      ctrl_d[`DTC_BIT_X0_REQ] = ~sync2_q[PinX0]; // Follows the source [R3] [R4]
    end
    if (ctrl_q[`DTC_BIT_X1_TYPE]) begin
      if (!wrCtrl && ackExtOne) begin
        ctrl_d[`DTC_BIT_X1_REQ] = 1'b0; // [R4]
      end
      if (x1Fall) begin
        ctrl_d[`DTC_BIT_X1_REQ] = 1'b1; // [R3] [R5]
      end
    end else begin
      ctrl_d[`DTC_BIT_X1_REQ] = ~sync2_q[PinX1]; // [R3] [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `DTC_RESET_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Timer two: run bit, and pin counting or every core clock
  assign t2Baud = t2ctrl_q[`DTC_BIT_T2_RXSRC] | t2ctrl_q[`DTC_BIT_T2_TXSRC];
  assign tick2 = t2ctrl_q[`DTC_BIT_T2_RUN] && // [R19]
                 (t2ctrl_q[`DTC_BIT_T2_FSEL] ? cntEdge_q[2] : 1'b1); // [R20]
  assign t2Ovf = tick2 && (t2_q == `DTC_WORD_ONES);

  // Timer two count and reload/capture words; writes take priority
  always_comb begin
    t2_d = t2_q;
    rcap_d = rcap_q;
    if (t2Ovf && (t2Baud || !t2ctrl_q[`DTC_BIT_T2_CAPSEL])) begin
      t2_d = rcap_q; // Reload on overflow [R21] [R22]
    end else if (t2Trig && !t2Baud && !t2ctrl_q[`DTC_BIT_T2_CAPSEL]) begin
      t2_d = rcap_q; // Reload on trigger edge [R18] [R21]
    end else if (tick2) begin
      t2_d = t2_q + 16'h0001;
    end
    if (t2Trig && !t2Baud && t2ctrl_q[`DTC_BIT_T2_CAPSEL]) begin
      rcap_d = t2_q; // Capture on trigger edge [R21]
    end
    if (regWrite && regAddr == `DTC_ADDR_T2_LOW) begin
      t2_d[7:0] = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T2_HIGH) begin
      t2_d[15:8] = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T2_RELOAD_LOW) begin
      rcap_d[7:0] = regWdata;
    end
    if (regWrite && regAddr == `DTC_ADDR_T2_RELOAD_HIGH) begin
      rcap_d[15:8] = regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      t2_q <= 16'h0000;
      rcap_q <= 16'h0000;
    end else begin
      t2_q <= t2_d;
      rcap_q <= rcap_d;
    end
  end

  // Timer two control; flags cleared by software only, set wins
  always_comb begin
    t2ctrl_d = wrT2Ctrl ? regWdata : t2ctrl_q; // [R17] [R19] [R20] [R21]
    if (t2Ovf && !t2Baud) begin
      t2ctrl_d[`DTC_BIT_T2_OVF] = 1'b1; // [R15]
    end
    if (t2Trig) begin
      t2ctrl_d[`DTC_BIT_T2_EXT] = 1'b1; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      t2ctrl_q <= `DTC_RESET_BYTE;
    end else begin
      t2ctrl_q <= t2ctrl_d;
    end
  end

  // Baud overflow routing to the serial port
  always_ff @(posedge clk) begin
    if (reset) begin
      rxBaudTick <= 1'b0;
      txBaudTick <= 1'b0;
    end else begin
      rxBaudTick <= t2ctrl_q[`DTC_BIT_T2_RXSRC] ? t2Ovf : t1Ovf; // [R14] [R17]
      txBaudTick <= t2ctrl_q[`DTC_BIT_T2_TXSRC] ? t2Ovf : t1Ovf; // [R14] [R17]
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    unique case (regAddr)
      `DTC_ADDR_CTRL: rdMux = ctrl_q;
      `DTC_ADDR_MODE: rdMux = mode_q;
      `DTC_ADDR_T0_LOW: rdMux = tl0_q;
      `DTC_ADDR_T1_LOW: rdMux = tl1_q;
      `DTC_ADDR_T0_HIGH: rdMux = th0_q;
      `DTC_ADDR_T1_HIGH: rdMux = th1_q;
      `DTC_ADDR_T2_CTRL: rdMux = t2ctrl_q;
      `DTC_ADDR_T2_RELOAD_LOW: rdMux = rcap_q[7:0];
      `DTC_ADDR_T2_RELOAD_HIGH: rdMux = rcap_q[15:8];
      `DTC_ADDR_T2_LOW: rdMux = t2_q[7:0];
      `DTC_ADDR_T2_HIGH: rdMux = t2_q[15:8];
      default: rdMux = `DTC_RESET_BYTE;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata <= `DTC_RESET_BYTE;
    end else begin
      regRdata <= regRead ? rdMux : `DTC_RESET_BYTE;
    end
  end

  // Interrupt request outputs mirror the flags one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      timerZeroIrq <= 1'b0;
      timerOneIrq <= 1'b0;
      extZeroIrq <= 1'b0;
      extOneIrq <= 1'b0;
      timerTwoIrq <= 1'b0;
    end else begin
      timerZeroIrq <= ctrl_q[`DTC_BIT_T0_OVF];
      timerOneIrq <= ctrl_q[`DTC_BIT_T1_OVF];
      extZeroIrq <= ctrl_q[`DTC_BIT_X0_REQ];
      extOneIrq <= ctrl_q[`DTC_BIT_X1_REQ];
      timerTwoIrq <= t2ctrl_q[`DTC_BIT_T2_OVF] | t2ctrl_q[`DTC_BIT_T2_EXT];
    end
  end

endmodule

/* core/dtc_regs.svh */
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// Register addresses on the plain register port
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LOW 8'h8a
`define DTC_ADDR_T1_LOW 8'h8b
`define DTC_ADDR_T0_HIGH 8'h8c
`define DTC_ADDR_T1_HIGH 8'h8d
`define DTC_ADDR_T2_CTRL 8'hc8
`define DTC_ADDR_T2_RELOAD_LOW 8'hca
`define DTC_ADDR_T2_RELOAD_HIGH 8'hcb
`define DTC_ADDR_T2_LOW 8'hcc
`define DTC_ADDR_T2_HIGH 8'hcd

// Shared control register bit positions
`define DTC_BIT_T1_OVF 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_OVF 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_X1_REQ 3
`define DTC_BIT_X1_TYPE 2
`define DTC_BIT_X0_REQ 1
`define DTC_BIT_X0_TYPE 0

// Mode register fields
`define DTC_BIT_T1_GATE 7
`define DTC_BIT_T1_CNT 6
`define DTC_BIT_T1_MODE_HI 5
`define DTC_BIT_T1_MODE_LO 4
`define DTC_BIT_T0_GATE 3
`define DTC_BIT_T0_CNT 2
`define DTC_BIT_T0_MODE_HI 1
`define DTC_BIT_T0_MODE_LO 0

// Timer two control register bit positions
`define DTC_BIT_T2_OVF 7
`define DTC_BIT_T2_EXT 6
`define DTC_BIT_T2_RXSRC 5
`define DTC_BIT_T2_TXSRC 4
`define DTC_BIT_T2_EXEN 3
`define DTC_BIT_T2_RUN 2
`define DTC_BIT_T2_FSEL 1
`define DTC_BIT_T2_CAPSEL 0

// Reset values and counts
`define DTC_RESET_BYTE 8'h00
`define DTC_BYTE_ONES 8'hff
`define DTC_WORD_ONES 16'hffff
`define DTC_LOW5_ONES 5'h1f
`define DTC_MC_CLOCKS 12

`endif

/* core/dtc_pkg.sv */
package dtc_pkg;
  // Operating modes of timers zero and one
  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD8,
    DTC_MODE_SPLIT
  } dtc_mode_e;
  typedef logic [7:0] dtc_byte_t;
endpackage

/* tb/dtc_pin_model.sv */
`timescale 1ns/10ps
module dtc_pin_model #(
  parameter int HoldClocks = 24 // Clocks each level is held
) (
  input wire logic clk, // Core clock
  output logic timerZeroCountPin, // Timer zero count input
  output logic timerOneCountPin, // Timer one count input
  output logic extIrqZeroPinN, // External interrupt zero, active low
  output logic extIrqOnePinN, // External interrupt one, active low
  output logic timerTwoCountPin, // Timer two count input
  output logic timerTwoTriggerPin // Timer two trigger input
);
  // Bit order: t0 count, t1 count, ext0, ext1, t2 count, t2 trigger
  logic [5:0] pinLevel_q = 6'h3f; // Idle high, as with pull-ups
  assign {timerTwoTriggerPin, timerTwoCountPin, extIrqOnePinN, extIrqZeroPinN,
    timerOneCountPin, timerZeroCountPin} = pinLevel_q;
  // Two machine cycles a level, whatever the sampler phase
  task automatic setPin(input int idx, input logic v);
    @(posedge clk);
    pinLevel_q[idx] <= v;
    repeat (HoldClocks) @(posedge clk);
  endtask
  // One low pulse, high on return
  task automatic pulse(input int idx);
    setPin(idx, 1'b0);
    setPin(idx, 1'b1);
  endtask
endmodule

/* tb/dtc_timer_counter_properties.sv */
`timescale 1ns/10ps
module dtc_tc_checker #(
  parameter int McClocks = 12 // Core clocks per machine cycle
) (
  input wire logic clk, // Core clock
  input wire logic reset, // Synchronous reset
  input wire dtc_pkg::dtc_byte_t regAddr, // Register address
  input wire dtc_pkg::dtc_byte_t regWdata, // Register write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  input wire dtc_pkg::dtc_byte_t regRdata, // Read data
  input wire logic extIrqZeroPinN, // Ext zero pin
  input wire logic extIrqOnePinN, // Ext one pin
  input wire logic ackTimerZero, // Vector to timer zero
  input wire logic ackTimerOne, // Vector to timer one
  input wire logic timerZeroIrq, // Timer zero flag
  input wire logic timerOneIrq, // Timer one flag
  input wire logic extZeroIrq, // Ext zero flag
  input wire logic extOneIrq, // Ext one flag
  input wire logic timerTwoIrq, // Timer two flags
  input wire logic rxBaudTick, // Receive baud pulse
  input wire logic txBaudTick // Transmit baud pulse
);
  import dtc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Flag bits read back match the flag outputs
  AST_CTRL_FLAGS_MATCH: assert property (
    regRead && regAddr == 8'h88 |=> regRdata[7] == timerOneIrq && regRdata[5] == timerZeroIrq
      && regRdata[3] == extOneIrq && regRdata[1] == extZeroIrq)
    else $error("control flags differ from flag outputs");
  AST_T2_FLAGS_MATCH: assert property (
    regRead && regAddr == 8'hc8 |=> (regRdata[7] | regRdata[6]) == timerTwoIrq)
    else $error("timer two flags differ from its flag output");
  // Software bits read back as written
  AST_T2_CTRL_RW: assert property (
    regWrite && regAddr == 8'hc8 ##2 regRead && regAddr == 8'hc8
      |=> (regRdata & 8'h3f) == ($past(regWdata, 3) & 8'h3f))
    else $error("timer two control bits lost");
  // Vectored only with the timer stopped
  AST_T0_ACK_CLEARS: assert property (
    ackTimerZero && !(regWrite && regAddr == 8'h88) |-> ##2 !timerZeroIrq)
    else $error("timer zero flag not cleared by vectoring");
  AST_T1_ACK_CLEARS: assert property (
    ackTimerOne && !(regWrite && regAddr == 8'h88) |-> ##2 !timerOneIrq)
    else $error("timer one flag not cleared by vectoring");
  // A falling pin raises its request
  AST_X0_FALL_FLAG: assert property (
    $fell(extIrqZeroPinN) |-> ##[1:8] extZeroIrq)
    else $error("ext zero request missing after fall");
  AST_X1_FALL_FLAG: assert property (
    $fell(extIrqOnePinN) |-> ##[1:8] extOneIrq)
    else $error("ext one request missing after fall");
  AST_TX_TICK_PULSE: assert property (
    txBaudTick |=> !txBaudTick)
    else $error("transmit baud tick longer than one cycle");
  AST_RX_TICK_PULSE: assert property (
    rxBaudTick |=> !rxBaudTick)
    else $error("receive baud tick longer than one cycle");
endmodule

bind dtc_timer_counter dtc_tc_checker #(.McClocks(McClocks)) checkInst (
  .clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .extIrqZeroPinN,
  .extIrqOnePinN, .ackTimerZero, .ackTimerOne, .timerZeroIrq, .timerOneIrq, .extZeroIrq,
  .extOneIrq, .timerTwoIrq, .rxBaudTick, .txBaudTick
);

/* tb/dual_timer_counter_with_ext_irq_flags_tb_top.sv */
`timescale 1ns/10ps
module dual_timer_counter_with_ext_irq_flags_tb_top;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  dtc_byte_t regAddr = 8'h00;
  dtc_byte_t regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] ack = 4'h0; // Vector pulses: t0, t1, x0, x1
  dtc_byte_t regRdata, v;
  logic t0Pin, t1Pin, x0PinN, x1PinN, t2Pin, trigPin;
  logic timerZeroIrq, timerOneIrq, extZeroIrq, extOneIrq, timerTwoIrq, rxBaudTick, txBaudTick;
  logic [4:0] irqs;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int rxCnt = 0;
  int txCnt = 0;
  int snap;
  dtc_byte_t addrs [12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca, 8'hcb,
    8'hcc, 8'hcd, 8'h90};
  assign irqs = {timerTwoIrq, extOneIrq, extZeroIrq, timerOneIrq, timerZeroIrq};

  dtc_timer_counter uut (
    .clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .timerZeroCountPin(t0Pin),
    .timerOneCountPin(t1Pin), .extIrqZeroPinN(x0PinN), .extIrqOnePinN(x1PinN),
    .timerTwoCountPin(t2Pin), .timerTwoTriggerPin(trigPin), .ackTimerZero(ack[0]),
    .ackTimerOne(ack[1]), .ackExtZero(ack[2]), .ackExtOne(ack[3]),
    .timerZeroIrq, .timerOneIrq, .extZeroIrq, .extOneIrq, .timerTwoIrq, .rxBaudTick,
    .txBaudTick);
  dtc_pin_model pins (
    .clk(clk), .timerZeroCountPin(t0Pin), .timerOneCountPin(t1Pin), .extIrqZeroPinN(x0PinN),
    .extIrqOnePinN(x1PinN), .timerTwoCountPin(t2Pin), .timerTwoTriggerPin(trigPin));

  initial begin
    forever #10 clk = ~clk;
  end
  // Count one-cycle baud pulses rather than poll them
  always @(posedge clk) begin
    cycles++;
    if (rxBaudTick === 1'b1) rxCnt++;
    if (txBaudTick === 1'b1) txCnt++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input dtc_byte_t got, input dtc_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input dtc_byte_t a, input dtc_byte_t d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input dtc_byte_t a, output dtc_byte_t d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulseAck(input int i);
    @(posedge clk);
    ack[i] <= 1'b1;
    @(posedge clk);
    ack[i] <= 1'b0;
  endtask
  task automatic flagIs(input int i, input logic e);
    chk({7'h00, irqs[i]}, {7'h00, e});
  endtask
  task automatic waitIrq(input int i, input int limit);
    int n;
    n = 0;
    while (irqs[i] !== 1'b1 && n < limit) begin
      idle(1);
      n++;
    end
    flagIs(i, 1'b1);
  endtask
  // Preset, run to overflow, stop keeping flags, check bytes, then vector
  task automatic ovf(input dtc_byte_t md, hiA, hiV, loA, loV, runV, input int i,
    input dtc_byte_t expHi, expLo, loMask);
    wr(8'h89, md);
    wr(hiA, hiV);
    wr(loA, loV);
    wr(8'h88, runV);
    waitIrq(i, 60);
    wr(8'h88, 8'ha0);
    rd(hiA, v);
    chk(v, expHi);
    rd(loA, v);
    chk(v & loMask, expLo);
    pulseAck(i);
    idle(2);
    flagIs(i, 1'b0);
    wr(8'h88, 8'h00);
    $display("overflow case mode %h done", md);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // All registers and one hole read zero after reset
    foreach (addrs[k]) begin
      rd(addrs[k], v);
      chk(v, 8'h00);
    end
    wr(8'hc8, 8'h3f);
    rd(8'hc8, v);
    chk(v & 8'h3f, 8'h3f);
    wr(8'hc8, 8'h00);
    $display("reset and access done");
    snap = txCnt;
    ovf(8'h01, 8'h8c, 8'hff, 8'h8a, 8'hfe, 8'h10, 0, 8'h00, 8'h00, 8'hff);
    ovf(8'h00, 8'h8c, 8'hff, 8'h8a, 8'h1e, 8'h10, 0, 8'h00, 8'h00, 8'h1f);
    ovf(8'h20, 8'h8d, 8'hf0, 8'h8b, 8'hfe, 8'h40, 1, 8'hf0, 8'hf0, 8'hff);
    chk({7'h00, txCnt > snap}, 8'h01);
    ovf(8'h03, 8'h8c, 8'hfe, 8'h8a, 8'h33, 8'h40, 1, 8'h00, 8'h33, 8'hff);
    // Timer one in its mode 3 holds despite its run bit
    wr(8'h89, 8'h30);
    wr(8'h8b, 8'h55);
    wr(8'h88, 8'h40);
    idle(40);
    rd(8'h8b, v);
    chk(v, 8'h55);
    // With timer zero split, timer one runs by leaving mode 3, flagless
    wr(8'h88, 8'h00);
    wr(8'h8b, 8'hff);
    wr(8'h89, 8'h23);
    snap = txCnt;
    idle(60);
    chk({7'h00, txCnt > snap}, 8'h01);
    flagIs(1, 1'b0);
    wr(8'h89, 8'h33);
    idle(2);
    snap = txCnt;
    idle(40);
    chk({7'h00, txCnt == snap}, 8'h01);
    $display("mode 3 done");
    // Gate closed holds the count, and run does not clear it
    wr(8'h89, 8'h09);
    pins.setPin(2, 1'b0);
    wr(8'h8a, 8'h40);
    wr(8'h88, 8'h10);
    idle(30);
    rd(8'h8a, v);
    chk(v, 8'h40);
    pins.setPin(2, 1'b1);
    rd(8'h8a, v);
    chk({7'h00, v != 8'h40}, 8'h01);
    // Timer function: one count per twelve clocks, phase unknown
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    idle(119);
    wr(8'h88, 8'h00);
    rd(8'h8a, v);
    chk({7'h00, v >= 8'd10 && v <= 8'd11}, 8'h01);
    $display("gate and rate done");
    // Both count pins: three falls, three counts
    for (int i = 0; i < 2; i++) begin
      wr(8'h89, i ? 8'h50 : 8'h05);
      wr(i ? 8'h8b : 8'h8a, 8'h00);
      wr(8'h88, i ? 8'h40 : 8'h10);
      repeat (3) pins.pulse(i);
      wr(8'h88, 8'h00);
      rd(i ? 8'h8b : 8'h8a, v);
      chk(v, 8'h03);
    end
    $display("counter function done");
    // Edge requests latch, level requests follow the pin
    for (int i = 0; i < 2; i++) begin
      wr(8'h88, i ? 8'h04 : 8'h01);
      pins.pulse(2 + i);
      #1;
      flagIs(2 + i, 1'b1);
      rd(8'h88, v);
      chk(v & 8'h0a, i ? 8'h08 : 8'h02);
      pulseAck(2 + i);
      idle(2);
      flagIs(2 + i, 1'b0);
      wr(8'h88, 8'h00);
      pins.setPin(2 + i, 1'b0);
      #1;
      flagIs(2 + i, 1'b1);
      pulseAck(2 + i);
      idle(2);
      flagIs(2 + i, 1'b1);
      pins.setPin(2 + i, 1'b1);
      #1;
      flagIs(2 + i, 1'b0);
    end
    $display("external requests done");
    // Trigger pin raises the external flag only when enabled
    wr(8'hc8, 8'h08);
    pins.pulse(5);
    #1;
    flagIs(4, 1'b1);
    rd(8'hc8, v);
    chk(v & 8'hc0, 8'h40);
    wr(8'hc8, 8'h00);
    idle(2);
    flagIs(4, 1'b0);
    pins.pulse(5);
    #1;
    flagIs(4, 1'b0);
    // Capture takes the running count
    wr(8'hcd, 8'h12);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h0d);
    pins.pulse(5);
    wr(8'hc8, 8'h00);
    rd(8'hcb, v);
    chk(v, 8'h12);
    // Counter function of timer two follows its pin
    wr(8'hcd, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h06);
    repeat (2) pins.pulse(4);
    wr(8'hc8, 8'h00);
    rd(8'hcc, v);
    chk(v, 8'h02);
    // Baud use: ticks, no flag, forced reload
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    snap = rxCnt;
    wr(8'hc8, 8'h3d);
    idle(60);
    chk({7'h00, rxCnt > snap}, 8'h01);
    flagIs(4, 1'b0);
    rd(8'hcd, v);
    chk(v, 8'hff);
    wr(8'hc8, 8'h04);
    waitIrq(4, 40);
    wr(8'hc8, 8'h80);
    rd(8'hcd, v);
    chk(v, 8'hff);
    wr(8'hc8, 8'h00);
    $display("timer two done");
    give_verdict();
  end
endmodule
